// ==== core/frame_accept_config.sv ====
// Implementation choice: register access over AHB-Lite.
`default_nettype none
// Notes on behaviour
// R1: bits 7..6 of sync_min add zero to three 00 bytes ahead of B2 4D.
// R2: bits 5..0 times four give the lower bound; shorter frames are dropped.
// R3: at 106 kbit/s without sync detection the lower bound is not checked.
// R4: max bits 5..0 times four give the upper bound; longer frames drop.
// R5: a max field of zero accepts frames of up to 256 bytes.
// R6: at 106 kbit/s without sync detection the upper bound is not checked.
// R7: with hold set, autocoll ends only on a command after select or poll.
// R8: with hold set, active communication is refused.
// R9: at 424 kbit/s active, the half-slot bit gives half the 212 kbit/s slot.
// R10: at 424 kbit/s active, half-slot clear gives the full 212 kbit/s slot.
// R11: software or the internal state machine can set the halt status bit.
// R12: while halted only request code 52h is taken as a request.
// R13: an RF reset clears the halt status bit.
// R14: wait field and bit phase give extra delay at 106 passive or autocoll.
// R15: bits 7..5 of type A set the Miller decoder sensitivity.
// R16: bits 4..3 of type A set the Miller decoder time constant.
// R17: a frame outside the length window is neither delivered nor reported; the code still pulses frameReject and clears status bit 0.
module frame_accept_config (
  input wire logic clock,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // receive path and protocol events
  input wire frame_accept_pkg::rx_byte_type rxIn,
  input wire frame_accept_pkg::rate_type rxRate,
  input wire logic syncDetectEnable,
  input wire logic activeMode,
  input wire logic autoCollRunning,
  input wire logic selectDone,
  input wire logic pollingDone,
  input wire logic validCommand,
  input wire logic haltEnter,
  input wire logic rfResetPin,
  input wire logic requestSeen,
  input wire logic [7:0] requestCode,
  input wire logic [6:0] transmitBitPhase,
  // outputs
  output logic frameAccept,
  output logic frameReject,
  output logic autoCollEnd,
  output logic activeRefused,
  output logic requestTaken,
  output logic [8:0] extraResponseDelay,
  output var frame_accept_pkg::decoder_cfg_type decoderCfg
);
  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  frame_accept_pkg::sync_min_type syncMin_q;
  frame_accept_pkg::sync_min_type syncMin_d;
  frame_accept_pkg::max_slot_type maxSlot_q;
  frame_accept_pkg::max_slot_type maxSlot_d;
  logic [7:0] typeA_q;
  logic [7:0] typeA_d;
  logic wrPend_q;
  logic wrPend_d;
  logic [15:0] wrIdx_q;
  logic [15:0] wrIdx_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [15:0] addrIdx;
  logic take;
  logic [7:0] rdByte;
  logic haltSet;
  logic haltClear;
  logic rfSync1_q;
  logic rfSync2_q;
  logic rfSync3_q;
  logic rfResetPulse;
  logic lastGood_q;
  logic autoWait_q;
  logic activeRefused_q;

  assign addrIdx = haddr[17:2];
  assign take = hsel && hready && htrans[1] &&
    hsize == frame_accept_pkg::HSIZE_WORD;

  // rf reset arrives from the analog side: two stages, then an edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rfSync1_q <= 1'b0;
      rfSync2_q <= 1'b0;
      rfSync3_q <= 1'b0;
    end else begin
      rfSync1_q <= rfResetPin;
      rfSync2_q <= rfSync1_q;
      rfSync3_q <= rfSync2_q;
    end
  end
  assign rfResetPulse = rfSync2_q && !rfSync3_q;

  assign haltSet = haltEnter; // [R11]
  assign haltClear = rfResetPulse; // [R13]

  always_comb begin
    if (addrIdx == frame_accept_pkg::SYNC_MIN_IDX) begin
      rdByte = syncMin_q;
    end else if (addrIdx == frame_accept_pkg::MAX_SLOT_IDX) begin
      rdByte = maxSlot_q;
    end else if (addrIdx == frame_accept_pkg::TYPEA_IDX) begin
      rdByte = typeA_q;
    end else if (addrIdx == frame_accept_pkg::STATUS_IDX) begin
      rdByte = {5'h00, autoWait_q, activeRefused_q, lastGood_q};
    end else begin
      rdByte = 8'h00;
    end
  end

  always_comb begin
    syncMin_d = syncMin_q;
    maxSlot_d = maxSlot_q;
    typeA_d = typeA_q;
    wrPend_d = 1'b0;
    wrIdx_d = wrIdx_q;
    rdata_d = rdata_q;
    if (take) begin
      wrPend_d = hwrite;
      wrIdx_d = addrIdx;
      if (!hwrite) begin
        rdata_d = {24'h000000, rdByte};
      end
    end
    if (wrPend_q) begin
      if (wrIdx_q == frame_accept_pkg::SYNC_MIN_IDX) begin
        syncMin_d = hwdata[7:0];
      end else if (wrIdx_q == frame_accept_pkg::MAX_SLOT_IDX) begin
        maxSlot_d = hwdata[7:0];
      end else if (wrIdx_q == frame_accept_pkg::TYPEA_IDX) begin
        typeA_d = hwdata[7:0];
      end
    end
    // hardware set beats the rf reset clear and a software write
    if (haltClear) begin
      typeA_d[frame_accept_pkg::HALT_BIT] = 1'b0; // [R13]
    end
    if (haltSet) begin
      typeA_d[frame_accept_pkg::HALT_BIT] = 1'b1; // [R11]
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      syncMin_q <= frame_accept_pkg::SYNC_MIN_RESET;
      maxSlot_q <= frame_accept_pkg::MAX_SLOT_RESET;
      typeA_q <= frame_accept_pkg::TYPEA_RESET;
      wrPend_q <= 1'b0;
      wrIdx_q <= 16'h0000;
      rdata_q <= 32'h00000000;
    end else begin
      syncMin_q <= syncMin_d;
      maxSlot_q <= maxSlot_d;
      typeA_q <= typeA_d;
      wrPend_q <= wrPend_d;
      wrIdx_q <= wrIdx_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // --------------------------------------------------------------
  // length window
  // --------------------------------------------------------------
  logic [8:0] minBytes;
  logic [8:0] maxBytes;
  logic checkEnable;
  logic frameDone;
  logic frameGood;

  assign minBytes = {3'h0, syncMin_q.minFrameLength}
    << frame_accept_pkg::LEN_UNIT_SHIFT; // [R2]
  assign maxBytes = (maxSlot_q.maxFrameLength == 6'h00) ?
    frame_accept_pkg::LEN_ZERO_MAX : // [R5]
    ({3'h0, maxSlot_q.maxFrameLength} <<
    frame_accept_pkg::LEN_UNIT_SHIFT); // [R4]
  // no window at 106 kbit/s without sync detection
  assign checkEnable = !(rxRate == frame_accept_pkg::RATE_106 &&
    !syncDetectEnable); // [R3] [R6]

  frame_length_gate #(
    .LEN_WIDTH(9)
  ) lengthGate (
    .clock(clock),
    .rst_n(rst_n),
    .checkEnable(checkEnable),
    .minBytes(minBytes),
    .maxBytes(maxBytes),
    .rxIn(rxIn),
    .frameDone(frameDone),
    .frameGood(frameGood)
  );

  // --------------------------------------------------------------
  // protocol state
  // --------------------------------------------------------------
  logic accept_q;
  logic accept_d;
  logic reject_q;
  logic reject_d;
  logic lastGood_d;
  logic selected_q;
  logic selected_d;
  logic autoWait_d;
  logic autoEnd_q;
  logic autoEnd_d;
  logic activeRefused_d;
  logic reqTaken_q;
  logic reqTaken_d;
  logic [8:0] delay_q;
  logic [8:0] delay_d;
  frame_accept_pkg::decoder_cfg_type cfg_q;
  frame_accept_pkg::decoder_cfg_type cfg_d;
  logic holdSel;
  logic halted;

  assign holdSel = maxSlot_q.holdUntilSelection;
  assign halted = typeA_q[frame_accept_pkg::HALT_BIT];

  always_comb begin
    accept_d = frameDone && frameGood; // [R17]
    reject_d = frameDone && !frameGood; // [R17]
    lastGood_d = frameDone ? frameGood : lastGood_q;
    autoWait_d = holdSel && autoCollRunning;
    selected_d = selected_q;
    autoEnd_d = 1'b0;
    if (!autoCollRunning) begin
      selected_d = 1'b0;
    end else if (selectDone || pollingDone) begin
      selected_d = 1'b1;
    end
    if (autoCollRunning && validCommand) begin
      // hold until a command follows a finished select or polling
      autoEnd_d = !holdSel || selected_q; // [R7]
    end
    activeRefused_d = holdSel && activeMode; // [R8]
    reqTaken_d = requestSeen &&
      (!halted || requestCode == frame_accept_pkg::REQ_ONLY_CODE); // [R12]
    delay_d = 9'h000;
    if ((rxRate == frame_accept_pkg::RATE_106 && !activeMode) ||
        autoCollRunning) begin
      delay_d = {typeA_q[frame_accept_pkg::WAIT_HI:frame_accept_pkg::WAIT_LO],
        transmitBitPhase}; // [R14]
    end
    cfg_d.millerDecoderSensitivity =
      typeA_q[frame_accept_pkg::SENS_HI:frame_accept_pkg::SENS_LO]; // [R15]
    cfg_d.millerDecoderTimeConstant =
      typeA_q[frame_accept_pkg::TAU_HI:frame_accept_pkg::TAU_LO]; // [R16]
    cfg_d.responseWaitExtra =
      typeA_q[frame_accept_pkg::WAIT_HI:frame_accept_pkg::WAIT_LO];
    cfg_d.slotLength = frame_accept_pkg::SLOT_212;
    if (activeMode && rxRate == frame_accept_pkg::RATE_424 &&
        maxSlot_q.halfSlotSelect) begin
      cfg_d.slotLength = frame_accept_pkg::SLOT_212 >> 1; // [R9]
    end // otherwise the full 212 slot [R10]
    cfg_d.syncBytes = 3'(syncMin_q.syncPreambleLength) + 3'h2; // [R1]
    cfg_d.syncPattern = {frame_accept_pkg::SYNC_ZERO,
      frame_accept_pkg::SYNC_ZERO, frame_accept_pkg::SYNC_ZERO,
      frame_accept_pkg::SYNC_HEAD, frame_accept_pkg::SYNC_TAIL}; // [R1]
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      accept_q <= 1'b0;
      reject_q <= 1'b0;
      lastGood_q <= 1'b0;
      selected_q <= 1'b0;
      autoWait_q <= 1'b0;
      autoEnd_q <= 1'b0;
      activeRefused_q <= 1'b0;
      reqTaken_q <= 1'b0;
      delay_q <= 9'h000;
      cfg_q <= '0;
    end else begin
      accept_q <= accept_d;
      reject_q <= reject_d;
      lastGood_q <= lastGood_d;
      selected_q <= selected_d;
      autoWait_q <= autoWait_d;
      autoEnd_q <= autoEnd_d;
      activeRefused_q <= activeRefused_d;
      reqTaken_q <= reqTaken_d;
      delay_q <= delay_d;
      cfg_q <= cfg_d;
    end
  end

  assign frameAccept = accept_q;
  assign frameReject = reject_q;
  assign autoCollEnd = autoEnd_q;
  assign activeRefused = activeRefused_q;
  assign requestTaken = reqTaken_q;
  assign extraResponseDelay = delay_q;
  assign decoderCfg = cfg_q;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  reject_no_accept_a: assert property ( // [R17]
    @(posedge clock) disable iff (!rst_n)
    frameDone && !frameGood |=> frameReject && !frameAccept)
    else $error("rejected frame reported as accepted");
  halt_request_a: assert property ( // [R12]
    @(posedge clock) disable iff (!rst_n)
    requestSeen && halted && requestCode != frame_accept_pkg::REQ_ONLY_CODE
    |=> !requestTaken) else $error("halted took wrong request");
  halt_rf_clear_a: assert property ( // [R13]
    @(posedge clock) disable iff (!rst_n)
    rfResetPulse && !haltEnter |=> !typeA_q[frame_accept_pkg::HALT_BIT])
    else $error("rf reset left halt set");
  halt_set_a: assert property ( // [R11]
    @(posedge clock) disable iff (!rst_n)
    haltEnter |=> typeA_q[frame_accept_pkg::HALT_BIT])
    else $error("halt not set");
  hold_active_a: assert property ( // [R8]
    @(posedge clock) disable iff (!rst_n)
    holdSel && activeMode |=> activeRefused) else $error("active allowed");
  hold_end_a: assert property ( // [R7]
    @(posedge clock) disable iff (!rst_n)
    autoCollEnd |-> !$past(holdSel) || $past(selected_q))
    else $error("autocoll ended early");
  half_slot_a: assert property ( // [R9]
    @(posedge clock) disable iff (!rst_n)
    activeMode && rxRate == frame_accept_pkg::RATE_424 &&
    maxSlot_q.halfSlotSelect |=> decoderCfg.slotLength ==
    (frame_accept_pkg::SLOT_212 >> 1)) else $error("slot not halved");
  full_slot_a: assert property ( // [R10]
    @(posedge clock) disable iff (!rst_n)
    !maxSlot_q.halfSlotSelect |=> decoderCfg.slotLength ==
    frame_accept_pkg::SLOT_212) else $error("slot not full");
endmodule
`default_nettype wire

// ==== core/frame_length_gate.sv ====
`default_nettype none
// --------------------------------------------------------------
// length window check on one frame
// --------------------------------------------------------------
module frame_length_gate #(
  parameter int LEN_WIDTH = 9
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic checkEnable,
  input wire logic [LEN_WIDTH-1:0] minBytes,
  input wire logic [LEN_WIDTH-1:0] maxBytes,
  input wire frame_accept_pkg::rx_byte_type rxIn,
  output logic frameDone,
  output logic frameGood
);
  logic [LEN_WIDTH-1:0] count_q;
  logic [LEN_WIDTH-1:0] count_d;
  logic over_q;
  logic over_d;
  logic done_q;
  logic done_d;
  logic good_q;
  logic good_d;
  logic [LEN_WIDTH-1:0] lenNow;

  always_comb begin
    count_d = count_q;
    over_d = over_q;
    done_d = 1'b0;
    good_d = good_q;
    lenNow = count_q + LEN_WIDTH'(1);
    if (rxIn.valid) begin
      if (count_q == '1) begin
        over_d = 1'b1;
      end else begin
        count_d = lenNow;
      end
      if (rxIn.last) begin
        done_d = 1'b1;
        // shorter or longer than the window is dropped
        good_d = !checkEnable ||
          (!over_q && lenNow >= minBytes && lenNow <= maxBytes);
        count_d = '0;
        over_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      over_q <= 1'b0;
      done_q <= 1'b0;
      good_q <= 1'b0;
    end else begin
      count_q <= count_d;
      over_q <= over_d;
      done_q <= done_d;
      good_q <= good_d;
    end
  end

  assign frameDone = done_q;
  assign frameGood = good_q;
endmodule
`default_nettype wire

// ==== inc/frame_accept_pkg.sv ====
`default_nettype none
package frame_accept_pkg;
  // register indices: one word per register, byte address is four times
  // the index
  localparam logic [15:0] SYNC_MIN_IDX = 16'h630a;
  localparam logic [15:0] MAX_SLOT_IDX = 16'h630b;
  localparam logic [15:0] TYPEA_IDX = 16'h630c;
  localparam logic [15:0] STATUS_IDX = 16'h630d;
  localparam logic [1:0] WORD_SHIFT = 2'h2;
  localparam logic [7:0] SYNC_MIN_RESET = 8'h00;
  localparam logic [7:0] MAX_SLOT_RESET = 8'h00;
  localparam logic [7:0] TYPEA_RESET = 8'h62;
  localparam int SYNC_LEN_HI = 7;
  localparam int SYNC_LEN_LO = 6;
  localparam int LEN_HI = 5;
  localparam int LEN_LO = 0;
  localparam int HOLD_SEL_BIT = 7;
  localparam int HALF_SLOT_BIT = 6;
  localparam int SENS_HI = 7;
  localparam int SENS_LO = 5;
  localparam int TAU_HI = 4;
  localparam int TAU_LO = 3;
  localparam int HALT_BIT = 2;
  localparam int WAIT_HI = 1;
  localparam int WAIT_LO = 0;
  localparam logic [8:0] LEN_UNIT_SHIFT = 9'h002;
  localparam logic [8:0] LEN_ZERO_MAX = 9'h100;
  localparam logic [7:0] REQ_ONLY_CODE = 8'h52;
  localparam logic [7:0] SYNC_HEAD = 8'hb2;
  localparam logic [7:0] SYNC_TAIL = 8'h4d;
  localparam logic [7:0] SYNC_ZERO = 8'h00;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [6:0] SLOT_212 = 7'h40;

  typedef enum logic [1:0] {
    RATE_106,
    RATE_212,
    RATE_424,
    RATE_848
  } rate_type;

  typedef struct packed {
    logic [1:0] syncPreambleLength;
    logic [5:0] minFrameLength;
  } sync_min_type;

  typedef struct packed {
    logic holdUntilSelection;
    logic halfSlotSelect;
    logic [5:0] maxFrameLength;
  } max_slot_type;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } rx_byte_type;

  typedef struct packed {
    logic [2:0] millerDecoderSensitivity;
    logic [1:0] millerDecoderTimeConstant;
    logic [1:0] responseWaitExtra;
    logic [6:0] slotLength;
    logic [39:0] syncPattern;
    logic [2:0] syncBytes;
  } decoder_cfg_type;
endpackage
`default_nettype wire

// ==== testbench/contactless_frame_accept_config_test.sv ====
`default_nettype none
module contactless_frame_accept_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  frame_accept_pkg::rx_byte_type rxIn;
  frame_accept_pkg::rate_type rxRate = frame_accept_pkg::RATE_212;
  logic syncDetectEnable = 1'b1;
  logic activeMode = 1'b0;
  logic autoCollRunning = 1'b0;
  logic selectDone = 1'b0;
  logic pollingDone = 1'b0;
  logic validCommand = 1'b0;
  logic haltEnter = 1'b0;
  logic rfResetPin = 1'b0;
  logic requestSeen = 1'b0;
  logic [7:0] requestCode = 8'h00;
  logic [6:0] transmitBitPhase = 7'h00;
  logic frameAccept;
  logic frameReject;
  logic autoCollEnd;
  logic activeRefused;
  logic requestTaken;
  logic [8:0] extraResponseDelay;
  frame_accept_pkg::decoder_cfg_type decoderCfg;
  int nMismatch = 0;
  int samplesChecked = 0;
  logic [31:0] rd;

  always #12.5 clock = ~clock;

  frame_accept_config u_dut (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxIn(rxIn), .rxRate(rxRate),
    .syncDetectEnable(syncDetectEnable), .activeMode(activeMode),
    .autoCollRunning(autoCollRunning), .selectDone(selectDone),
    .pollingDone(pollingDone), .validCommand(validCommand),
    .haltEnter(haltEnter), .rfResetPin(rfResetPin),
    .requestSeen(requestSeen), .requestCode(requestCode),
    .transmitBitPhase(transmitBitPhase), .frameAccept(frameAccept),
    .frameReject(frameReject), .autoCollEnd(autoCollEnd),
    .activeRefused(activeRefused), .requestTaken(requestTaken),
    .extraResponseDelay(extraResponseDelay), .decoderCfg(decoderCfg)
  );

  remote_frame_source u_peer (.clock(clock), .rxOut(rxIn));

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmpBit(input logic got, input logic exp, input string s);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %0t %s got %b exp %b", $time, s, got, exp);
    end
  endtask

  task automatic cmpWord(input logic [39:0] got, input logic [39:0] exp,
                         input string s);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // ahb-lite single word transfer; waits on hready, never on a count
  // ----------------------------------------------------------------
  task automatic ahbXfer(input logic wr, input logic [15:0] idx,
                         input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {14'h0, idx, 2'h0};
    htrans <= frame_accept_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= frame_accept_pkg::HSIZE_WORD;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic regWrite(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] dummy;
    ahbXfer(1'b1, idx, wd, dummy);
  endtask

  task automatic regCheck(input logic [15:0] idx, input logic [7:0] exp);
    ahbXfer(1'b0, idx, 32'h0, rd);
    cmpWord({8'h00, rd}, {32'h0, exp}, "register read");
    cmpBit(hresp, 1'b0, "okay response");
  endtask

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  // one-cycle event pulse; returns just after the edge that samples it
  task automatic tapEvent(input int k);
    @(posedge clock);
    case (k)
      0: selectDone <= 1'b1;
      1: pollingDone <= 1'b1;
      2: validCommand <= 1'b1;
      3: haltEnter <= 1'b1;
      default: requestSeen <= 1'b1;
    endcase
    @(posedge clock);
    {selectDone, pollingDone, validCommand, haltEnter, requestSeen} <= '0;
    #1;
  endtask

  task automatic frameCheck(input int len, input logic good);
    int i;
    u_peer.sendFrame(len);
    for (i = 0; i < 8; i++) begin
      @(posedge clock);
      #1;
      if ((frameAccept | frameReject) === 1'b1) break;
    end
    cmpBit(frameAccept, good, "frame accept");
    cmpBit(frameReject, !good, "frame reject");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    regCheck(frame_accept_pkg::SYNC_MIN_IDX, 8'h00);
    regCheck(frame_accept_pkg::MAX_SLOT_IDX, 8'h00);
    regCheck(frame_accept_pkg::TYPEA_IDX, 8'h62);
    regWrite(16'h6300, 32'hff);
    regCheck(16'h6300, 8'h00);
    for (int c = 0; c < 4; c++) begin
      regWrite(frame_accept_pkg::SYNC_MIN_IDX, {24'h0, c[1:0], 6'h00});
      settle();
      cmpWord(40'(decoderCfg.syncBytes), 40'(c + 2), "sync bytes");
      cmpWord(decoderCfg.syncPattern, 40'h000000b24d, "sync");
    end
    regWrite(frame_accept_pkg::SYNC_MIN_IDX, 32'h02);
    regWrite(frame_accept_pkg::MAX_SLOT_IDX, 32'h03);
    frameCheck(7, 1'b0);
    frameCheck(8, 1'b1);
    regCheck(frame_accept_pkg::STATUS_IDX, 8'h01);
    frameCheck(12, 1'b1);
    frameCheck(13, 1'b0);
    regCheck(frame_accept_pkg::STATUS_IDX, 8'h00);
    regWrite(frame_accept_pkg::MAX_SLOT_IDX, 32'h00);
    frameCheck(256, 1'b1);
    frameCheck(257, 1'b0);
    regWrite(frame_accept_pkg::MAX_SLOT_IDX, 32'h03);
    rxRate <= frame_accept_pkg::RATE_106;
    syncDetectEnable <= 1'b0;
    frameCheck(3, 1'b1);
    frameCheck(20, 1'b1);
    syncDetectEnable <= 1'b1;
    frameCheck(3, 1'b0);
    regWrite(frame_accept_pkg::MAX_SLOT_IDX, 32'h83);
    activeMode <= 1'b1;
    settle();
    cmpBit(activeRefused, 1'b1, "active refused");
    regCheck(frame_accept_pkg::STATUS_IDX, 8'h02);
    activeMode <= 1'b0;
    autoCollRunning <= 1'b1;
    tapEvent(2);
    cmpBit(autoCollEnd, 1'b0, "end without select");
    regCheck(frame_accept_pkg::STATUS_IDX, 8'h04);
    for (int k = 0; k < 2; k++) begin
      // a fresh autocoll run forgets the earlier select
      autoCollRunning <= 1'b0;
      @(posedge clock);
      autoCollRunning <= 1'b1;
      tapEvent(k);
      tapEvent(2);
      cmpBit(autoCollEnd, 1'b1, "end after select or poll");
    end
    rxRate <= frame_accept_pkg::RATE_424;
    activeMode <= 1'b1;
    regWrite(frame_accept_pkg::MAX_SLOT_IDX, 32'h43);
    settle();
    cmpBit(activeRefused, 1'b0, "active allowed");
    cmpWord(40'(decoderCfg.slotLength),
            40'(frame_accept_pkg::SLOT_212 >> 1), "short slot");
    regWrite(frame_accept_pkg::MAX_SLOT_IDX, 32'h03);
    settle();
    cmpWord(40'(decoderCfg.slotLength),
            40'(frame_accept_pkg::SLOT_212), "long slot");
    activeMode <= 1'b0;
    rxRate <= frame_accept_pkg::RATE_106;
    tapEvent(3);
    regCheck(frame_accept_pkg::TYPEA_IDX, 8'h66);
    requestCode <= 8'h26;
    tapEvent(4);
    cmpBit(requestTaken, 1'b0, "other request while halted");
    requestCode <= 8'h52;
    tapEvent(4);
    cmpBit(requestTaken, 1'b1, "request 52 while halted");
    rfResetPin <= 1'b1;
    settle();
    rfResetPin <= 1'b0;
    settle();
    regCheck(frame_accept_pkg::TYPEA_IDX, 8'h62);
    requestCode <= 8'h26;
    tapEvent(4);
    cmpBit(requestTaken, 1'b1, "request when not halted");
    regWrite(frame_accept_pkg::TYPEA_IDX, 32'h66);
    regCheck(frame_accept_pkg::TYPEA_IDX, 8'h66);
    regWrite(frame_accept_pkg::TYPEA_IDX, 32'h63);
    transmitBitPhase <= 7'h15;
    settle();
    cmpWord(40'(extraResponseDelay), 40'h195, "delay");
    rxRate <= frame_accept_pkg::RATE_212;
    autoCollRunning <= 1'b0;
    settle();
    cmpWord(40'(extraResponseDelay), 40'h0, "no delay");
    autoCollRunning <= 1'b1;
    settle();
    cmpWord(40'(extraResponseDelay), 40'h195, "autocoll delay");
    tapEvent(2);
    cmpBit(autoCollEnd, 1'b1, "end with hold clear");
    regWrite(frame_accept_pkg::TYPEA_IDX, 32'hba);
    settle();
    cmpWord(40'(decoderCfg.millerDecoderSensitivity), 40'h5, "sens");
    cmpWord(40'(decoderCfg.millerDecoderTimeConstant), 40'h3, "tau");
    cmpWord(40'(decoderCfg.responseWaitExtra), 40'h2, "wait");
    close_out();
  end

  // the whole sequence needs about thirteen hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    nMismatch++;
    close_out();
  end
endmodule
`default_nettype wire

// ==== testbench/remote_frame_source.sv ====
`default_nettype none
// ----------------------------------------------------------------
// far side: a reader or peer handing received bytes to the framer
// ----------------------------------------------------------------
module remote_frame_source (
  input wire logic clock,
  output var frame_accept_pkg::rx_byte_type rxOut
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxOut = '0;
  // between bytes the data lines show the inverse of the last byte so a
  // stale value can never be mistaken for a fresh one
  task automatic sendFrame(input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clock);
      rxOut <= '{1'b1, (i == len - 1), 8'(i)};
      @(posedge clock);
      rxOut <= '{1'b0, 1'b0, ~8'(i)};
    end
  endtask
endmodule
`default_nettype wire
